/* File: core/dio_pkg.sv */
// constants, layouts and carrier types of the four-channel output/input block
package dio_pkg;
  localparam int NCH = 4;
  // ****************************************
  // register indices
  // ****************************************
  localparam logic [3:0] REG_SET_OUT = 4'h0;
  localparam logic [3:0] REG_LED = 4'h1;
  localparam logic [3:0] REG_LEVEL = 4'h2;
  localparam logic [3:0] REG_SUMMARY = 4'h3;
  localparam logic [3:0] REG_OVERLOAD = 4'h4;
  localparam logic [3:0] REG_OPEN = 4'h5;
  localparam logic [3:0] REG_SHORT = 4'h6;
  localparam logic [3:0] REG_GLOBAL = 4'h7;
  localparam logic [3:0] REG_WIRE_GATE = 4'h8;
  localparam logic [3:0] REG_CFG_IN = 4'hC;
  localparam logic [3:0] REG_CFG_OUT = 4'hD;
  // ****************************************
  // field positions
  // ****************************************
  localparam int HDR_ADDR_LSB = 6;
  localparam int HDR_REG_LSB = 2;
  localparam int HDR_BURST = 1;
  localparam int HDR_WRITE = 0;
  localparam int SET_OUT_INPUT_LSB = 4;
  localparam int GATE_EN_LSB = 4;
  localparam int CFG_IN_TYPE2 = 7;
  localparam int CFG_IN_SYNC_HOLD = 6;
  localparam int CFG_IN_LOWLEAK_LSB = 0;
  // ****************************************
  // reset values and frame figures
  // ****************************************
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] DIAG_MARK = 8'h80;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [6:0] HDR_BITS = 7'h08;
  localparam logic [6:0] CRC_BITS = 7'h08;
  localparam logic [3:0] BURST_WR_BYTES = 4'h2;
  localparam logic [3:0] BURST_RD_BYTES = 4'h6;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    DRV_HIGH_SIDE = 2'b00,
    DRV_HIGH_SIDE_2X = 2'b01,
    DRV_CLAMP_PP = 2'b10,
    DRV_SIMPLE_PP = 2'b11
  } drive_e;
  typedef struct packed {
    logic [3:0] overload;
    logic [3:0] open_wire;
    logic [3:0] supply_short;
    logic [7:0] global_f;
  } fault_s;
endpackage : dio_pkg

/* File: core/sync_cell.sv */
// two-stage synchroniser for a bundle of levels
`timescale 1ns/1ps
module sync_cell #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : sync_cell

/* File: core/dio_spi_core.sv */
// serial register and diagnostic interface of a four-channel output/input device
// Function
// - gate drive on only while its enable bit in register 0x08 is one
// - input and low-leakage modes hold gate drive at field supply, transistor off
// - faults set flag bits in read-only registers 0x03 to 0x07
// - burst write updates 0x00 and 0x01 together, and nothing else
// - burst read returns 0x02 through 0x07 in order in one frame
// - every frame shifts fresh diagnostic bits out on the data output
// - strap pin selects whether frames carry and are checked by a CRC
// - two strap pins give chip address; other addresses are ignored
// - sync input lets several devices update outputs together
// - output mode offers four drive types per channel
// - one global input type applies to all input channels
// - low-leakage high-impedance mode as third channel mode
// - output channel follows parallel input or its output-high bit
// - single global sink current setting, no per-channel mixing
`timescale 1ns/1ps
module dio_spi_core (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  input wire logic multi_device_sync,
  input wire logic crc_select_strap,
  input wire logic address_strap_low,
  input wire logic address_strap_high,
  input wire dio_pkg::fault_s fault_in,
  input wire logic [3:0] field_channel_level,
  input wire logic [3:0] parallel_channel_in,
  output logic [3:0] parallel_channel_out,
  output logic [3:0] parallel_channel_oe,
  output logic [3:0] gate_drive_outputs,
  output logic [3:0] field_drive_on,
  output dio_pkg::drive_e [3:0] field_drive_type,
  output logic [3:0] field_hiz,
  output logic [3:0] input_mode,
  output logic input_sink_type2
);
  // ****************************************
  // link side, runs on the serial clock
  // ****************************************
  logic [6:0] bit_cnt;
  logic [7:0] shift, hdr, wd0, wd1, crc;
  logic [6:0] frame_bits;
  logic frame_tgl;
  logic [7:0] reg_view [0:15];
  logic [7:0] snap [0:5];
  logic [1:0] chip_addr;
  logic crc_on;

  wire [7:0] next_shift = {shift[6:0], spi_mosi};
  wire byte_done = &bit_cnt[2:0];
  wire [3:0] byte_idx = bit_cnt[6:3];
  wire [7:0] crc_base = (bit_cnt == 7'h00) ? 8'h00 : crc;
  wire crc_fb = crc_base[7] ^ spi_mosi;
  wire [7:0] next_crc = {crc_base[6:0], 1'b0} ^ (crc_fb ? dio_pkg::CRC_POLY : 8'h00);
  wire [3:0] hdr_reg = hdr[dio_pkg::HDR_REG_LSB +: 4];
  wire hdr_burst = hdr[dio_pkg::HDR_BURST];
  wire [3:0] rd_off = hdr_burst ? byte_idx - 4'h1 : 4'h0;
  wire [3:0] rd_idx = hdr_reg + rd_off;
  // only the own address answers with register data
  wire rd_hit = !hdr[dio_pkg::HDR_WRITE] && hdr[dio_pkg::HDR_ADDR_LSB +: 2] == chip_addr
    && (hdr_burst ? (hdr_reg == dio_pkg::REG_LEVEL && byte_idx <= dio_pkg::BURST_RD_BYTES)
                  : byte_idx == 4'h1);
  // header byte always carries marker plus fault summary
  wire [7:0] diag_byte = dio_pkg::DIAG_MARK | {4'h0, snap[1][3:0]};
  wire [7:0] tx_byte = (byte_idx == 4'h0) ? diag_byte : (rd_hit ? reg_view[rd_idx] : 8'h00);

  // counter cleared by the frame's own select, since the clock stops between frames
  always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) bit_cnt <= 7'h00;
    else bit_cnt <= bit_cnt + 7'h01;
  end

  always_ff @(posedge spi_sclk or negedge resetn) begin
    if (!resetn) begin
      shift <= dio_pkg::RST_REG;
      crc <= dio_pkg::RST_REG;
      frame_bits <= 7'h00;
      frame_tgl <= 1'b0;
    end else begin
      shift <= next_shift;
      crc <= next_crc;
      frame_bits <= bit_cnt + 7'h01;
      frame_tgl <= frame_tgl ^ (bit_cnt == 7'h00);
    end
  end

  always_ff @(posedge spi_sclk or negedge resetn) begin
    if (!resetn) begin
      hdr <= dio_pkg::RST_REG;
      wd0 <= dio_pkg::RST_REG;
      wd1 <= dio_pkg::RST_REG;
    end else if (byte_done) begin
      if (byte_idx == 4'h0) hdr <= next_shift;
      if (byte_idx == 4'h1) wd0 <= next_shift;
      if (byte_idx == 4'h2) wd1 <= next_shift;
    end
  end

  // first bit is the constant marker so it can be preset while deselected
  always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) spi_miso <= 1'b1;
    else spi_miso <= tx_byte[~bit_cnt[2:0]];
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic cs_q, cs_q_d;
  logic [32:0] pin_q;
  dio_pkg::fault_s fs;
  logic tgl_q, sync_q, sync_q_d, crc_strap_q, tgl_seen;
  logic [1:0] addr_q, strap_cnt;
  logic [3:0] level_q, par_q;

  sync_cell #(.W(1), .INIT(1'b1)) u_cs_sync (
    .clk(ref_clk),
    .resetn(resetn),
    .d(spi_cs_n),
    .q(cs_q)
  );
  sync_cell #(.W(33)) u_pin_sync (
    .clk(ref_clk),
    .resetn(resetn),
    .d({frame_tgl, multi_device_sync, crc_select_strap, address_strap_high,
        address_strap_low, fault_in, field_channel_level, parallel_channel_in}),
    .q(pin_q)
  );
  assign {tgl_q, sync_q, crc_strap_q, addr_q, fs, level_q, par_q} = pin_q;

  wire cs_fall = cs_q_d && !cs_q;
  wire cs_rise = !cs_q_d && cs_q;
  wire sync_rise = sync_q && !sync_q_d;
  wire frame_end = cs_rise && (tgl_q != tgl_seen);

  // straps are sampled on the first three cycles after reset, then held; the last sample is taken after the synchronisers have settled
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      strap_cnt <= 2'h0;
      chip_addr <= 2'h0;
      crc_on <= 1'b0;
    end else if (strap_cnt != dio_pkg::STRAP_SETTLE) begin
      strap_cnt <= strap_cnt + 2'h1;
      chip_addr <= addr_q;
      crc_on <= crc_strap_q;
    end
  end

  // ****************************************
  // frame decode at end of selection
  // ****************************************
  logic [7:0] set_out_pend, set_out_live, led_reg, wire_gate, cfg_in, cfg_out;
  logic [3:0] over_l, open_l, short_l;
  logic [7:0] glob_l;

  wire f_write = hdr[dio_pkg::HDR_WRITE];
  wire [3:0] n_bytes = hdr_burst ? (f_write ? dio_pkg::BURST_WR_BYTES
                                            : dio_pkg::BURST_RD_BYTES) : 4'h1;
  // burst write only from 0x00, burst read only from 0x02
  wire burst_ok = !hdr_burst
    || (f_write ? hdr_reg == dio_pkg::REG_SET_OUT : hdr_reg == dio_pkg::REG_LEVEL);
  wire [6:0] exp_bits = dio_pkg::HDR_BITS + {n_bytes[3:0], 3'b000}
    + (crc_on ? dio_pkg::CRC_BITS : 7'h00);
  wire addr_ok = hdr[dio_pkg::HDR_ADDR_LSB +: 2] == chip_addr;
  wire crc_ok = !crc_on || crc == 8'h00;
  wire commit = frame_end && addr_ok && burst_ok && crc_ok && frame_bits == exp_bits;
  wire wr_commit = commit && f_write;
  wire rd_commit = commit && !f_write;
  wire rd_over = rd_commit && (hdr_burst || hdr_reg == dio_pkg::REG_OVERLOAD);
  wire rd_open = rd_commit && (hdr_burst || hdr_reg == dio_pkg::REG_OPEN);
  wire rd_short = rd_commit && (hdr_burst || hdr_reg == dio_pkg::REG_SHORT);
  wire rd_glob = rd_commit && (hdr_burst || hdr_reg == dio_pkg::REG_GLOBAL);

  // read clears only what was reported; a live condition sets again
  wire [3:0] next_over = fs.overload | (over_l & ~(rd_over ? snap[2][3:0] : 4'h0));
  wire [3:0] next_open = fs.open_wire | (open_l & ~(rd_open ? snap[3][3:0] : 4'h0));
  wire [3:0] next_short = fs.supply_short | (short_l & ~(rd_short ? snap[4][3:0] : 4'h0));
  wire [7:0] next_glob = fs.global_f | (glob_l & ~(rd_glob ? snap[5] : 8'h00));
  wire [7:0] summary = {4'h0, |glob_l, |short_l, |open_l, |over_l};
  wire hold = cfg_in[dio_pkg::CFG_IN_SYNC_HOLD];
  wire [7:0] next_live = (!hold || sync_rise) ? set_out_pend : set_out_live;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cs_q_d <= 1'b1;
      sync_q_d <= 1'b0;
      tgl_seen <= 1'b0;
    end else begin
      cs_q_d <= cs_q;
      sync_q_d <= sync_q;
      if (cs_rise) tgl_seen <= tgl_q;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      over_l <= 4'h0;
      open_l <= 4'h0;
      short_l <= 4'h0;
      glob_l <= 8'h00;
    end else begin
      over_l <= next_over;
      open_l <= next_open;
      short_l <= next_short;
      glob_l <= next_glob;
    end
  end

  // snapshot held still for the whole frame; host waits before first clock edge
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int k = 0; k < 6; k++) snap[k] <= dio_pkg::RST_REG;
    end else if (cs_fall) begin
      snap[0] <= {4'h0, level_q};
      snap[1] <= summary;
      snap[2] <= {4'h0, over_l};
      snap[3] <= {4'h0, open_l};
      snap[4] <= {4'h0, short_l};
      snap[5] <= glob_l;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      set_out_pend <= dio_pkg::RST_REG;
      led_reg <= dio_pkg::RST_REG;
      wire_gate <= dio_pkg::RST_REG;
      cfg_in <= dio_pkg::RST_REG;
      cfg_out <= dio_pkg::RST_REG;
    end else if (wr_commit && hdr_burst) begin
      set_out_pend <= wd0;
      led_reg <= wd1;
    end else if (wr_commit) begin
      case (hdr_reg)
        dio_pkg::REG_SET_OUT: set_out_pend <= wd0;
        dio_pkg::REG_LED: led_reg <= wd0;
        dio_pkg::REG_WIRE_GATE: wire_gate <= wd0;
        dio_pkg::REG_CFG_IN: cfg_in <= wd0;
        dio_pkg::REG_CFG_OUT: cfg_out <= wd0;
        default: ;
      endcase
    end
  end

  // register views read by the link side; only the listed ones are mapped
  always_comb begin
    for (int k = 0; k < 16; k++) reg_view[k] = 8'h00;
    reg_view[dio_pkg::REG_SET_OUT] = set_out_pend;
    reg_view[dio_pkg::REG_LED] = led_reg;
    for (int k = 0; k < 6; k++) reg_view[dio_pkg::REG_LEVEL + k] = snap[k];
    reg_view[dio_pkg::REG_WIRE_GATE] = wire_gate;
    reg_view[dio_pkg::REG_CFG_IN] = cfg_in;
    reg_view[dio_pkg::REG_CFG_OUT] = cfg_out;
  end

  // ****************************************
  // channel drive
  // ****************************************
  wire [3:0] in_sel = set_out_live[dio_pkg::SET_OUT_INPUT_LSB +: 4];
  wire [3:0] low_leak = cfg_in[dio_pkg::CFG_IN_LOWLEAK_LSB +: 4];
  wire [3:0] out_mode = ~in_sel & ~low_leak;
  wire [3:0] next_gate = out_mode & wire_gate[dio_pkg::GATE_EN_LSB +: 4];
  wire [3:0] next_on = out_mode & (par_q | set_out_live[3:0]);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      set_out_live <= dio_pkg::RST_REG;
      gate_drive_outputs <= 4'h0;
      field_drive_on <= 4'h0;
      field_hiz <= 4'h0;
      input_mode <= 4'h0;
      parallel_channel_out <= 4'h0;
      parallel_channel_oe <= 4'h0;
      input_sink_type2 <= 1'b0;
    end else begin
      set_out_live <= next_live;
      gate_drive_outputs <= next_gate;
      field_drive_on <= next_on;
      field_hiz <= low_leak;
      input_mode <= in_sel & ~low_leak;
      parallel_channel_out <= level_q;
      parallel_channel_oe <= in_sel & ~low_leak;
      input_sink_type2 <= cfg_in[dio_pkg::CFG_IN_TYPE2];
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < dio_pkg::NCH; ch++) begin : g_drv
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) field_drive_type[ch] <= dio_pkg::DRV_HIGH_SIDE;
        else field_drive_type[ch] <= dio_pkg::drive_e'(cfg_out[2*ch +: 2]);
      end
    end
  endgenerate

  // ****************************************
  // checks
  // ****************************************
  AST_GATE_NEEDS_ENABLE: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    ##1 (gate_drive_outputs & ~$past(wire_gate[7:4])) == 4'h0)
    else $error("gate drive on without its enable bit");
  AST_GATE_OFF_NON_OUTPUT: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    ##1 (gate_drive_outputs & $past(in_sel | low_leak)) == 4'h0)
    else $error("gate drive on in input or low-leakage mode");
  AST_FAULT_LATCHES: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    fs.overload != 4'h0 |=> (over_l & $past(fs.overload)) == $past(fs.overload))
    else $error("overload condition not latched");
  AST_BURST_WRITE_PAIR: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    wr_commit && hdr_burst |=> set_out_pend == $past(wd0) && led_reg == $past(wd1))
    else $error("burst write did not load both registers");
  AST_BAD_CRC_IGNORED: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    frame_end && crc_on && crc != 8'h00
    |=> $stable(wire_gate) && $stable(set_out_pend) && $stable(cfg_in))
    else $error("frame with bad check byte changed a register");
  AST_OTHER_ADDR_IGNORED: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    frame_end && !addr_ok |=> $stable(wire_gate) && $stable(set_out_pend) && $stable(glob_l)
      || $past(fs.global_f) != 8'h00)
    else $error("frame for another address was taken");
  AST_SYNC_HOLDS_OUTPUT: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    hold && !sync_rise |=> $stable(set_out_live))
    else $error("held outputs changed without sync edge");
  AST_CHANNEL_FOLLOWS: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    out_mode[0] && (par_q[0] || set_out_live[0]) |=> field_drive_on[0])
    else $error("output channel did not switch on");
  AST_LATCH_KEPT: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    !rd_glob |=> (glob_l & $past(glob_l)) == $past(glob_l))
    else $error("global flag lost without a read");
  AST_MARK_FIRST: assert property (
    @(posedge spi_sclk) disable iff (spi_cs_n)
    bit_cnt == 7'h00 |-> spi_miso)
    else $error("frame did not open with marker bit");
endmodule : dio_spi_core

/* File: test/host_spi_model.sv */
// host-side serial controller model that frames register transfers
`timescale 1ns/1ps
module host_spi_model (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic crc_on
);
  logic [7:0] tx [0:8];
  logic [7:0] rx [0:8];
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b1;
  end
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ dio_pkg::CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction : crc8
  // tx[0] carries chip address and burst flag chosen by the caller
  task automatic frame(input int n, input logic flip);
    logic [7:0] c;
    int nb;
    c = 8'h00;
    nb = n;
    for (int k = 0; k < n; k++) begin
      c = crc8(c, tx[k]);
    end
    if (crc_on) begin // check byte only when strapped; flip corrupts it on purpose
      tx[n] = c ^ {7'h00, flip};
      nb = n + 1;
    end
    spi_cs_n = 1'b0;
    #100;
    for (int k = 0; k < nb; k++) begin
      for (int i = 7; i >= 0; i--) begin
        spi_mosi = tx[k][i];
        #7.5;
        spi_sclk = 1'b1;
        rx[k][i] = spi_miso;
        #7.5;
        spi_sclk = 1'b0;
      end
    end
    #10;
    spi_cs_n = 1'b1;
    // released line must not keep showing the last bit
    spi_mosi = ~spi_mosi;
    #120;
  endtask : frame
endmodule : host_spi_model

/* File: test/tb_top.sv */
// self-checking bench for the serial register and diagnostic block
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, resetn, sync_in, crc_strap, addr_lo, addr_hi;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso;
  dio_pkg::fault_s faults;
  logic [3:0] level, par_in, par_out, par_oe, gate, drive_on, hiz, in_mode;
  dio_pkg::drive_e [3:0] dtype;
  logic sink2;
  logic [1:0] chip;
  logic [7:0] d;
  int num_errors = 0;
  int n_compared = 0;
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  dio_spi_core dio_spi_core_i (.ref_clk(ref_clk), .resetn(resetn), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .multi_device_sync(sync_in), .crc_select_strap(crc_strap),
    .address_strap_low(addr_lo), .address_strap_high(addr_hi), .fault_in(faults),
    .field_channel_level(level), .parallel_channel_in(par_in),
    .parallel_channel_out(par_out), .parallel_channel_oe(par_oe),
    .gate_drive_outputs(gate), .field_drive_on(drive_on), .field_drive_type(dtype),
    .field_hiz(hiz), .input_mode(in_mode), .input_sink_type2(sink2));
  host_spi_model host_spi_model_i (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .crc_on(crc_strap));
  // ****************************************
  // tasks
  // ****************************************
  task automatic stop_test();
    $display("mismatches %0d of %0d compared", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // acceptance plus output update is a few cycles; eight leaves margin
  task automatic settle();
    repeat (8) @(posedge ref_clk);
  endtask : settle
  task automatic xfer(input int n, input logic [3:0] rg, input logic bst, input logic w,
      input logic flip);
    host_spi_model_i.tx[0] = {chip, rg, bst, w};
    host_spi_model_i.frame(n, flip);
    settle();
  endtask : xfer
  task automatic wr(input logic [3:0] rg, input logic [7:0] v);
    host_spi_model_i.tx[1] = v;
    xfer(2, rg, 1'b0, 1'b1, 1'b0);
  endtask : wr
  task automatic rd(input logic [3:0] rg, output logic [7:0] v);
    host_spi_model_i.tx[1] = 8'h00;
    xfer(2, rg, 1'b0, 1'b0, 1'b0);
    v = host_spi_model_i.rx[1];
  endtask : rd
  task automatic do_reset(input logic crc, input logic [1:0] a);
    resetn <= 1'b0;
    crc_strap <= crc;
    {addr_hi, addr_lo} <= a;
    chip = a;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask : do_reset
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    sync_in <= 1'b0;
    faults <= '0;
    level <= 4'h6;
    par_in <= 4'h0;
    do_reset(1'b0, 2'b00);
    check({gate, hiz}, 8'h00);
    rd(dio_pkg::REG_WIRE_GATE, d);
    check(d, dio_pkg::RST_REG);
    wr(dio_pkg::REG_WIRE_GATE, 8'h50);
    check({4'h0, gate}, 8'h05);
    wr(dio_pkg::REG_WIRE_GATE, 8'hF0);
    rd(dio_pkg::REG_WIRE_GATE, d);
    check(d, 8'hF0);
    wr(dio_pkg::REG_SET_OUT, 8'h35);
    check({in_mode, par_oe}, 8'h33);
    check({4'h0, par_out}, 8'h06);
    check({gate, drive_on}, 8'hC4);
    wr(dio_pkg::REG_CFG_IN, 8'h88);
    check({hiz, gate}, 8'h84);
    check({7'h00, sink2}, 8'h01);
    wr(dio_pkg::REG_CFG_IN, 8'h00);
    wr(dio_pkg::REG_SET_OUT, 8'h00);
    par_in <= 4'hA;
    settle();
    check({gate, drive_on}, 8'hFA);
    wr(dio_pkg::REG_CFG_OUT, 8'hE4);
    check(dtype, 8'hE4);
    par_in <= 4'h0;
    host_spi_model_i.tx[2] = 8'h5A;
    host_spi_model_i.tx[1] = 8'h03;
    xfer(3, dio_pkg::REG_SET_OUT, 1'b1, 1'b1, 1'b0);
    check({4'h0, drive_on}, 8'h03);
    check(host_spi_model_i.rx[0], 8'h80);
    rd(dio_pkg::REG_LED, d);
    check(d, 8'h5A);
    host_spi_model_i.tx[1] = 8'h03;
    xfer(3, dio_pkg::REG_WIRE_GATE, 1'b1, 1'b1, 1'b0);
    check({4'h0, gate}, 8'h0F);
    chip = 2'b01;
    wr(dio_pkg::REG_WIRE_GATE, 8'h00);
    chip = 2'b00;
    check({4'h0, gate}, 8'h0F);
    // one byte too many must drop the whole frame
    xfer(3, dio_pkg::REG_WIRE_GATE, 1'b0, 1'b1, 1'b0);
    check({4'h0, gate}, 8'h0F);
    faults <= {4'h2, 4'h0, 4'h0, 8'h01};
    settle();
    for (int k = 1; k < 7; k++) begin
      host_spi_model_i.tx[k] = 8'h00;
    end
    xfer(7, dio_pkg::REG_LEVEL, 1'b1, 1'b0, 1'b0);
    check(host_spi_model_i.rx[0], 8'h89);
    check(host_spi_model_i.rx[1], 8'h06);
    check(host_spi_model_i.rx[2], 8'h09);
    check(host_spi_model_i.rx[3], 8'h02);
    check(host_spi_model_i.rx[4], 8'h00);
    check(host_spi_model_i.rx[5], 8'h00);
    check(host_spi_model_i.rx[6], 8'h01);
    faults <= '0;
    settle();
    rd(dio_pkg::REG_SUMMARY, d);
    check(d, 8'h09);
    rd(dio_pkg::REG_GLOBAL, d);
    check(d, 8'h01);
    rd(dio_pkg::REG_GLOBAL, d);
    check(d, 8'h00);
    rd(dio_pkg::REG_OVERLOAD, d);
    check(d, 8'h02);
    rd(dio_pkg::REG_OVERLOAD, d);
    check(d, 8'h00);
    check(host_spi_model_i.rx[0], 8'h80);
    wr(dio_pkg::REG_CFG_IN, 8'h40);
    wr(dio_pkg::REG_SET_OUT, 8'h0F);
    check({4'h0, drive_on}, 8'h03);
    sync_in <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sync_in <= 1'b0;
    settle();
    check({4'h0, drive_on}, 8'h0F);
    do_reset(1'b1, 2'b10);
    check({gate, drive_on}, 8'h00);
    wr(dio_pkg::REG_WIRE_GATE, 8'hF0);
    check({4'h0, gate}, 8'h0F);
    host_spi_model_i.tx[1] = 8'h00;
    xfer(2, dio_pkg::REG_WIRE_GATE, 1'b0, 1'b1, 1'b1);
    check({4'h0, gate}, 8'h0F);
    chip = 2'b00;
    wr(dio_pkg::REG_WIRE_GATE, 8'h00);
    check({4'h0, gate}, 8'h0F);
    stop_test();
  end
  // watchdog: the whole run needs well under this
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
endmodule : tb_top
